// file: include/conv_pkg.sv
// Behaviour
// - Primary selector: three pairs plus shorted test
// - Auxiliary selector: three pins or temperature sensor
// - No valid result until settling after switch
// - Range field picks one of eight spans
// - Auxiliary converter keeps one fixed range
// - Unipolar bit changes only the output coding
// - Unipolar: straight binary, zero gives zeros
// - Bipolar: offset binary, zero gives midscale
// - One bit switches both burnout currents together
// - Burnout currents follow the selected input pair
// - Excitation sources separate or combined on one pin
// - Eight-bit decimation word sets update rate
package conv_pkg;
    // ==========================================================
    // Register offsets (byte addresses)
    localparam logic [7:0] OFS_PRI_CFG = 8'h00;
    localparam logic [7:0] OFS_AUX_CFG = 8'h04;
    localparam logic [7:0] OFS_CUR_CTL = 8'h08;
    localparam logic [7:0] OFS_DEC_WORD = 8'h0C;
    localparam logic [7:0] OFS_STATUS = 8'h10;
    localparam logic [7:0] OFS_PRI_DATA = 8'h14;
    localparam logic [7:0] OFS_AUX_DATA = 8'h18;
    // ==========================================================
    // Field positions
    localparam int CHAN_LSB = 0;
    localparam int RANGE_LSB = 2;
    localparam int UNI_BIT = 5;
    localparam int EXC_A_BIT = 0;
    localparam int EXC_B_BIT = 1;
    localparam int ROUTE_LSB = 2;
    localparam int BURNOUT_BIT = 6;
    // ==========================================================
    // Reset values
    localparam logic [7:0] PRI_CFG_RST = 8'h00;
    localparam logic [7:0] AUX_CFG_RST = 8'h00;
    localparam logic [7:0] CUR_CTL_RST = 8'h00;
    localparam logic [7:0] DEC_WORD_RST = 8'h45;
    // ==========================================================
    // Primary channel codes and pin numbers
    localparam logic [1:0] PRI_CH_12 = 2'h0;
    localparam logic [1:0] PRI_CH_34 = 2'h1;
    localparam logic [1:0] PRI_CH_32 = 2'h2;
    localparam logic [1:0] PRI_CH_22 = 2'h3;
    localparam logic [2:0] PIN_1 = 3'h1;
    localparam logic [2:0] PIN_2 = 3'h2;
    localparam logic [2:0] PIN_3 = 3'h3;
    localparam logic [2:0] PIN_4 = 3'h4;
    localparam logic [1:0] AUX_CH_TEMP = 2'h3;
    localparam logic [2:0] AUX_FIXED_RANGE = 3'h0;
    // ==========================================================
    // Excitation routing codes
    localparam logic [1:0] ROUTE_SPLIT = 2'h0;
    localparam logic [1:0] ROUTE_PIN1 = 2'h1;
    localparam logic [1:0] ROUTE_PIN2 = 2'h2;
    // Modulator clocks per decimation step
    localparam int DEC_UNIT = 16;
endpackage

// file: include/conv_if.sv
`timescale 1ns/1ps
interface conv_if #(parameter int W = 24);
    logic [1:0] chan;
    logic [2:0] gain;
    logic uni;
    logic [7:0] dec;
    logic [W-1:0] raw;
    logic [W-1:0] code;
    logic done;
    logic settling;
    logic [1:0] act_chan;
    logic [2:0] act_gain;
    logic act_uni;
    // Register side drives settings and raw samples
    modport ctl (output chan, gain, uni, dec, raw,
        input code, done, settling, act_chan, act_gain, act_uni);
    // Sequencer side returns coded results and active settings
    modport conv (input chan, gain, uni, dec, raw,
        output code, done, settling, act_chan, act_gain, act_uni);
endinterface

// file: rtl/conv_seq.sv
`timescale 1ns/1ps
module conv_seq #(
    parameter int W = 24,
    parameter int UNIT = conv_pkg::DEC_UNIT,
    parameter bit HAS_GAIN = 1'b1
) (
    input wire logic clk,
    input wire logic rst_n,
    conv_if.conv cif
);
    typedef enum logic {ST_START, ST_RUN} seq_t;
    localparam logic [15:0] UNIT_W = 16'(UNIT);
    seq_t st_ff;
    logic [15:0] cnt_ff;
    logic [15:0] period_ff;
    logic [1:0] chan_ff;
    logic [2:0] gain_ff;
    logic uni_ff;
    logic first_ff;
    logic discard_ff;
    logic [W-1:0] raw_ff;
    logic [W-1:0] code_ff;
    logic done_ff;
    logic [1:0] ends_ff;
    logic conv_end;
    logic [7:0] nxt_dec;

    // Result coding from signed filter output
    function automatic logic [W-1:0] code_of(input logic [W-1:0] r, input logic u);
        logic [W-1:0] c;
        c = r;
        if (!u)
        begin
            c[W-1] = ~r[W-1];
        end
        else if (r[W-1])
        begin
            c = '0;
        end
        else
        begin
            c = {r[W-2:0], &r[W-2:0]};
        end
        return c;
    endfunction

    assign conv_end = (st_ff == ST_RUN) && (cnt_ff == period_ff - 16'h0001);
    assign nxt_dec = (cif.dec == 8'h00) ? 8'h01 : cif.dec;

    // Conversion sequencer: latch settings at start, count period
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_ff <= ST_START;
            cnt_ff <= 16'h0000;
            period_ff <= 16'h0001;
            chan_ff <= 2'h0;
            gain_ff <= 3'h0;
            uni_ff <= 1'b0;
            first_ff <= 1'b1;
            discard_ff <= 1'b1;
        end
        else
        begin
            case (st_ff)
                ST_START:
                begin
                    chan_ff <= cif.chan;
                    gain_ff <= HAS_GAIN ? cif.gain : conv_pkg::AUX_FIXED_RANGE;
                    uni_ff <= cif.uni;
                    period_ff <= {8'h00, nxt_dec} * UNIT_W;
                    discard_ff <= first_ff || (cif.chan != chan_ff);
                    first_ff <= 1'b0;
                    cnt_ff <= 16'h0000;
                    st_ff <= ST_RUN;
                end
                default:
                begin
                    cnt_ff <= cnt_ff + 16'h0001;
                    if (conv_end)
                    begin
                        st_ff <= ST_START;
                    end
                end
            endcase
        end
    end

    // Result capture; first conversion after a switch is dropped
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            raw_ff <= '0;
            code_ff <= '0;
            done_ff <= 1'b0;
        end
        else
        begin
            done_ff <= conv_end && !discard_ff;
            if (conv_end && !discard_ff)
            begin
                raw_ff <= cif.raw;
                code_ff <= code_of(cif.raw, uni_ff);
            end
        end
    end

    assign cif.code = code_ff;
    assign cif.done = done_ff;
    assign cif.settling = discard_ff;
    assign cif.act_chan = chan_ff;
    assign cif.act_gain = gain_ff;
    assign cif.act_uni = uni_ff;

    // Helper: conversions ended since last channel switch
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            ends_ff <= 2'h0;
        else if (st_ff == ST_START && (first_ff || cif.chan != chan_ff))
            ends_ff <= 2'h0;
        else if (conv_end && ends_ff != 2'h3)
            ends_ff <= ends_ff + 2'h1;
    end

    property p_settle;
        @(posedge clk) disable iff (!rst_n) done_ff |-> ends_ff >= 2'h2;
    endproperty
    a_settle: assert property (p_settle) else $error("Result before settling");

    property p_hold;
        @(posedge clk) disable iff (!rst_n)
            (st_ff == ST_RUN) |=> $stable(chan_ff) && $stable(gain_ff) && $stable(uni_ff);
    endproperty
    a_hold: assert property (p_hold) else $error("Settings changed mid conversion");

    property p_unipolar;
        @(posedge clk) disable iff (!rst_n)
            done_ff && uni_ff && raw_ff[W-1] |-> code_ff == '0;
    endproperty
    a_unipolar: assert property (p_unipolar) else $error("Unipolar floor wrong");

    property p_bipolar;
        @(posedge clk) disable iff (!rst_n)
            done_ff && !uni_ff |-> code_ff[W-1] == !raw_ff[W-1] && code_ff[W-2:0] == raw_ff[W-2:0];
    endproperty
    a_bipolar: assert property (p_bipolar) else $error("Offset binary wrong");

    property p_period;
        @(posedge clk) disable iff (!rst_n)
            (st_ff == ST_START) |=> period_ff == {8'h00, $past(nxt_dec)} * UNIT_W;
    endproperty
    a_period: assert property (p_period) else $error("Period not from decimation word");
endmodule

// file: rtl/conv_ctrl.sv
`timescale 1ns/1ps
module conv_ctrl #(
    parameter int PW = 24,
    parameter int AW = 16,
    parameter int UNIT = conv_pkg::DEC_UNIT
) (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    input wire logic [PW-1:0] PRI_RAW,
    input wire logic [AW-1:0] AUX_RAW,
    output logic [2:0] PRI_POS_PIN,
    output logic [2:0] PRI_NEG_PIN,
    output logic [2:0] PRI_GAIN,
    output logic [1:0] AUX_SRC,
    output logic AUX_TEMP_SEL,
    output logic BURNOUT_SRC_EN,
    output logic BURNOUT_SINK_EN,
    output logic [2:0] BURNOUT_POS_PIN,
    output logic [2:0] BURNOUT_NEG_PIN,
    output logic EXC_A_PIN1,
    output logic EXC_A_PIN2,
    output logic EXC_B_PIN1,
    output logic EXC_B_PIN2,
    output logic PRI_DONE,
    output logic AUX_DONE
);
    // ==========================================================
    // Declarations
    logic [7:0] pri_cfg_ff;
    logic [7:0] aux_cfg_ff;
    logic [7:0] cur_ctl_ff;
    logic [7:0] dec_word_ff;
    logic pri_rdy_ff;
    logic aux_rdy_ff;
    logic wr_ff;
    logic [7:0] addr_ff;
    logic [31:0] rdata_ff;
    logic acc;
    logic rd_acc;
    logic rd_pri;
    logic rd_aux;
    logic [1:0] route;

    conv_if #(.W(PW)) pri_if ();
    conv_if #(.W(AW)) aux_if ();

    // Positive pin of a primary channel code
    function automatic logic [2:0] pos_pin(input logic [1:0] ch);
        logic [2:0] p;
        p = conv_pkg::PIN_1;
        case (ch)
            conv_pkg::PRI_CH_12: p = conv_pkg::PIN_1;
            conv_pkg::PRI_CH_34: p = conv_pkg::PIN_3;
            conv_pkg::PRI_CH_32: p = conv_pkg::PIN_3;
            default: p = conv_pkg::PIN_2;
        endcase
        return p;
    endfunction

    // Negative pin of a primary channel code
    function automatic logic [2:0] neg_pin(input logic [1:0] ch);
        logic [2:0] p;
        p = conv_pkg::PIN_2;
        case (ch)
            conv_pkg::PRI_CH_12: p = conv_pkg::PIN_2;
            conv_pkg::PRI_CH_34: p = conv_pkg::PIN_4;
            conv_pkg::PRI_CH_32: p = conv_pkg::PIN_2;
            default: p = conv_pkg::PIN_2;
        endcase
        return p;
    endfunction

    // ==========================================================
    // Bus slave: zero wait states, always OKAY
    assign acc = HSEL && HTRANS[1] && HREADY;
    assign rd_acc = acc && !HWRITE;
    assign rd_pri = rd_acc && (HADDR[7:0] == conv_pkg::OFS_PRI_DATA);
    assign rd_aux = rd_acc && (HADDR[7:0] == conv_pkg::OFS_AUX_DATA);
    assign HREADYOUT = 1'b1;
    assign HRESP = 1'b0;
    assign HRDATA = rdata_ff;

    // Address phase capture
    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            wr_ff <= 1'b0;
            addr_ff <= 8'h00;
        end
        else
        begin
            wr_ff <= acc && HWRITE;
            if (acc)
            begin
                addr_ff <= HADDR[7:0];
            end
        end
    end

    // Read data registered at the address phase
    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
            rdata_ff <= 32'h0000_0000;
        else if (rd_acc)
        begin
            if (HADDR[7:0] == conv_pkg::OFS_PRI_CFG)
                rdata_ff <= {24'h00_0000, pri_cfg_ff};
            else if (HADDR[7:0] == conv_pkg::OFS_AUX_CFG)
                rdata_ff <= {24'h00_0000, aux_cfg_ff};
            else if (HADDR[7:0] == conv_pkg::OFS_CUR_CTL)
                rdata_ff <= {24'h00_0000, cur_ctl_ff};
            else if (HADDR[7:0] == conv_pkg::OFS_DEC_WORD)
                rdata_ff <= {24'h00_0000, dec_word_ff};
            else if (HADDR[7:0] == conv_pkg::OFS_STATUS)
                rdata_ff <= {28'h000_0000, aux_if.settling, pri_if.settling,
                    aux_rdy_ff, pri_rdy_ff};
            else if (HADDR[7:0] == conv_pkg::OFS_PRI_DATA)
                rdata_ff <= 32'(pri_if.code);
            else if (HADDR[7:0] == conv_pkg::OFS_AUX_DATA)
                rdata_ff <= 32'(aux_if.code);
            else
                rdata_ff <= 32'h0000_0000;
        end
    end

    // Configuration writes in the data phase
    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            pri_cfg_ff <= conv_pkg::PRI_CFG_RST;
            aux_cfg_ff <= conv_pkg::AUX_CFG_RST;
            cur_ctl_ff <= conv_pkg::CUR_CTL_RST;
            dec_word_ff <= conv_pkg::DEC_WORD_RST;
        end
        else if (wr_ff)
        begin
            if (addr_ff == conv_pkg::OFS_PRI_CFG)
                pri_cfg_ff <= HWDATA[7:0] & 8'h3F;
            else if (addr_ff == conv_pkg::OFS_AUX_CFG)
                aux_cfg_ff <= HWDATA[7:0] & 8'h23; // No range bits
            else if (addr_ff == conv_pkg::OFS_CUR_CTL)
                cur_ctl_ff <= HWDATA[7:0] & 8'h4F;
            else if (addr_ff == conv_pkg::OFS_DEC_WORD)
                dec_word_ff <= HWDATA[7:0];
        end
    end

    // Ready flags: a new result wins over a clearing read
    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            pri_rdy_ff <= 1'b0;
            aux_rdy_ff <= 1'b0;
        end
        else
        begin
            if (pri_if.done)
                pri_rdy_ff <= 1'b1;
            else if (rd_pri)
                pri_rdy_ff <= 1'b0;
            if (aux_if.done)
                aux_rdy_ff <= 1'b1;
            else if (rd_aux)
                aux_rdy_ff <= 1'b0;
        end
    end

    // ==========================================================
    // Converter sequencers
    assign pri_if.chan = pri_cfg_ff[conv_pkg::CHAN_LSB +: 2];
    assign pri_if.gain = pri_cfg_ff[conv_pkg::RANGE_LSB +: 3];
    assign pri_if.uni = pri_cfg_ff[conv_pkg::UNI_BIT];
    assign pri_if.dec = dec_word_ff;
    assign pri_if.raw = PRI_RAW;
    assign aux_if.chan = aux_cfg_ff[conv_pkg::CHAN_LSB +: 2];
    assign aux_if.gain = conv_pkg::AUX_FIXED_RANGE;
    assign aux_if.uni = aux_cfg_ff[conv_pkg::UNI_BIT];
    assign aux_if.dec = dec_word_ff;
    assign aux_if.raw = AUX_RAW;

    conv_seq #(.W(PW), .UNIT(UNIT), .HAS_GAIN(1'b1)) u_pri (
        .clk(CLK),
        .rst_n(RST_N),
        .cif(pri_if.conv)
    );

    conv_seq #(.W(AW), .UNIT(UNIT), .HAS_GAIN(1'b0)) u_aux (
        .clk(CLK),
        .rst_n(RST_N),
        .cif(aux_if.conv)
    );

    // ==========================================================
    // Analog front end controls, from active settings; burnout enables straight from the current control register
    assign route = cur_ctl_ff[conv_pkg::ROUTE_LSB +: 2];

    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            PRI_POS_PIN <= conv_pkg::PIN_1;
            PRI_NEG_PIN <= conv_pkg::PIN_2;
            PRI_GAIN <= 3'h0;
            AUX_SRC <= 2'h0;
            AUX_TEMP_SEL <= 1'b0;
            BURNOUT_SRC_EN <= 1'b0;
            BURNOUT_SINK_EN <= 1'b0;
            BURNOUT_POS_PIN <= conv_pkg::PIN_1;
            BURNOUT_NEG_PIN <= conv_pkg::PIN_2;
            PRI_DONE <= 1'b0;
            AUX_DONE <= 1'b0;
        end
        else
        begin
            PRI_POS_PIN <= pos_pin(pri_if.act_chan);
            PRI_NEG_PIN <= neg_pin(pri_if.act_chan);
            PRI_GAIN <= pri_if.act_gain;
            AUX_SRC <= aux_if.act_chan;
            AUX_TEMP_SEL <= (aux_if.act_chan == conv_pkg::AUX_CH_TEMP);
            BURNOUT_SRC_EN <= cur_ctl_ff[conv_pkg::BURNOUT_BIT];
            BURNOUT_SINK_EN <= cur_ctl_ff[conv_pkg::BURNOUT_BIT];
            BURNOUT_POS_PIN <= pos_pin(pri_if.act_chan);
            BURNOUT_NEG_PIN <= neg_pin(pri_if.act_chan);
            PRI_DONE <= pri_if.done;
            AUX_DONE <= aux_if.done;
        end
    end

    // Excitation routing: split or both onto one pin
    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            EXC_A_PIN1 <= 1'b0;
            EXC_A_PIN2 <= 1'b0;
            EXC_B_PIN1 <= 1'b0;
            EXC_B_PIN2 <= 1'b0;
        end
        else
        begin
            EXC_A_PIN1 <= cur_ctl_ff[conv_pkg::EXC_A_BIT]
                && (route != conv_pkg::ROUTE_PIN2);
            EXC_A_PIN2 <= cur_ctl_ff[conv_pkg::EXC_A_BIT]
                && (route == conv_pkg::ROUTE_PIN2);
            EXC_B_PIN1 <= cur_ctl_ff[conv_pkg::EXC_B_BIT]
                && (route == conv_pkg::ROUTE_PIN1);
            EXC_B_PIN2 <= cur_ctl_ff[conv_pkg::EXC_B_BIT]
                && (route != conv_pkg::ROUTE_PIN1);
        end
    end

    // ==========================================================
    // Checks on the front end controls
    property p_burnout_pair;
        @(posedge CLK) disable iff (!RST_N) BURNOUT_SRC_EN == BURNOUT_SINK_EN;
    endproperty
    a_burnout_pair: assert property (p_burnout_pair) else $error("Burnout halves differ");

    property p_burnout_route;
        @(posedge CLK) disable iff (!RST_N)
            BURNOUT_SRC_EN |-> BURNOUT_POS_PIN == PRI_POS_PIN && BURNOUT_NEG_PIN == PRI_NEG_PIN;
    endproperty
    a_burnout_route: assert property (p_burnout_route) else $error("Burnout off pair");

    property p_exc_combine;
        @(posedge CLK) disable iff (!RST_N)
            route == conv_pkg::ROUTE_PIN1 && cur_ctl_ff[1:0] == 2'h3 && $stable(cur_ctl_ff)
            |=> EXC_A_PIN1 && EXC_B_PIN1 && !EXC_A_PIN2 && !EXC_B_PIN2;
    endproperty
    a_exc_combine: assert property (p_exc_combine) else $error("Sources not combined");

    // Primary pair is always one of the three pairings or the shorted test
    property p_pri_pair;
        @(posedge CLK) disable iff (!RST_N)
            (PRI_POS_PIN == conv_pkg::PIN_1 && PRI_NEG_PIN == conv_pkg::PIN_2)
            || (PRI_POS_PIN == conv_pkg::PIN_3 && PRI_NEG_PIN == conv_pkg::PIN_4)
            || (PRI_POS_PIN == conv_pkg::PIN_3 && PRI_NEG_PIN == conv_pkg::PIN_2)
            || (PRI_POS_PIN == conv_pkg::PIN_2 && PRI_NEG_PIN == conv_pkg::PIN_2);
    endproperty
    a_pri_pair: assert property (p_pri_pair) else $error("Primary pair not legal");

    // Auxiliary converter never leaves its single range
    property p_aux_range;
        @(posedge CLK) disable iff (!RST_N) aux_if.act_gain == conv_pkg::AUX_FIXED_RANGE;
    endproperty
    a_aux_range: assert property (p_aux_range) else $error("Auxiliary range not fixed");

    // Each excitation source feeds at most one pin
    property p_exc_single;
        @(posedge CLK) disable iff (!RST_N)
            !(EXC_A_PIN1 && EXC_A_PIN2) && !(EXC_B_PIN1 && EXC_B_PIN2);
    endproperty
    a_exc_single: assert property (p_exc_single) else $error("Source on two pins");
endmodule

// file: test/sensor_model.sv
`timescale 1ns/1ps
// ==========================================
// Resistive sensors on the analog pins
module sensor_model #(
    parameter int PW = 24,
    parameter int AW = 16
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [PW-1:0] pri_level,
    input wire logic [AW-1:0] aux_level,
    input wire logic bo_src,
    input wire logic bo_sink,
    output logic [PW-1:0] pri_raw,
    output logic [AW-1:0] aux_raw
);
    // Filtered readings; burnout current through a sound bridge adds one step
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pri_raw <= '0;
            aux_raw <= '0;
        end
        else
        begin
            pri_raw <= pri_level + PW'(bo_src & bo_sink);
            aux_raw <= aux_level;
        end
    end
endmodule

// file: test/tb_top.sv
`timescale 1ns/1ps
// ==========================================
// Self-checking bench for the converter control block
module tb_top;
    localparam int UNIT = 2;
    localparam int P45 = 1 + 69 * UNIT;
    typedef struct packed {
        logic [7:0] pri;
        logic [7:0] aux;
        logic [7:0] cur;
        logic [16:0] outs;
    } row_t;
    typedef struct packed {
        logic [23:0] raw;
        logic uni;
        logic [23:0] code;
    } code_t;
    logic CLK, RST_N, HSEL, HWRITE, HREADYOUT, HRESP;
    logic [1:0] HTRANS, AUX_SRC;
    logic [2:0] HSIZE, PRI_POS_PIN, PRI_NEG_PIN, PRI_GAIN, BURNOUT_POS_PIN, BURNOUT_NEG_PIN;
    logic [31:0] HADDR, HWDATA, HRDATA, rd;
    logic [23:0] PRI_RAW, pri_level;
    logic [15:0] AUX_RAW, aux_level;
    logic AUX_TEMP_SEL, BURNOUT_SRC_EN, BURNOUT_SINK_EN, PRI_DONE, AUX_DONE;
    logic EXC_A_PIN1, EXC_A_PIN2, EXC_B_PIN1, EXC_B_PIN2;
    int bad_count = 0;
    int checks_done = 0;
    int n;
    // Settings beside the pin states they should give
    row_t rows [4] = '{
        '{8'h00, 8'h00, 8'h43, {3'h1, 3'h2, 3'h0, 2'h0, 1'b0, 4'h9, 1'b1}},
        '{8'h1D, 8'h21, 8'h47, {3'h3, 3'h4, 3'h7, 2'h1, 1'b0, 4'hA, 1'b1}},
        '{8'hEA, 8'hFE, 8'h0B, {3'h3, 3'h2, 3'h2, 2'h2, 1'b0, 4'h5, 1'b0}},
        '{8'h13, 8'h03, 8'h0D, {3'h2, 3'h2, 3'h4, 2'h3, 1'b1, 4'h8, 1'b0}}
    };
    // Raw filter words beside the coded results
    code_t codes [7] = '{
        '{24'h00_0000, 1'b0, 24'h80_0000},
        '{24'h80_0000, 1'b0, 24'h00_0000},
        '{24'h7F_FFFF, 1'b0, 24'hFF_FFFF},
        '{24'h00_0000, 1'b1, 24'h00_0000},
        '{24'h40_0000, 1'b1, 24'h80_0000},
        '{24'h7F_FFFF, 1'b1, 24'hFF_FFFF},
        '{24'hFF_FFF0, 1'b1, 24'h00_0000}
    };
    logic [7:0] decs [4] = '{8'h00, 8'h01, 8'h05, 8'hFF};

    conv_ctrl #(.UNIT(UNIT)) uut (.CLK(CLK), .RST_N(RST_N), .HSEL(HSEL), .HADDR(HADDR),
        .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA),
        .HREADY(HREADYOUT), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
        .PRI_RAW(PRI_RAW), .AUX_RAW(AUX_RAW), .PRI_POS_PIN(PRI_POS_PIN),
        .PRI_NEG_PIN(PRI_NEG_PIN), .PRI_GAIN(PRI_GAIN), .AUX_SRC(AUX_SRC),
        .AUX_TEMP_SEL(AUX_TEMP_SEL), .BURNOUT_SRC_EN(BURNOUT_SRC_EN),
        .BURNOUT_SINK_EN(BURNOUT_SINK_EN), .BURNOUT_POS_PIN(BURNOUT_POS_PIN),
        .BURNOUT_NEG_PIN(BURNOUT_NEG_PIN), .EXC_A_PIN1(EXC_A_PIN1), .EXC_A_PIN2(EXC_A_PIN2),
        .EXC_B_PIN1(EXC_B_PIN1), .EXC_B_PIN2(EXC_B_PIN2), .PRI_DONE(PRI_DONE),
        .AUX_DONE(AUX_DONE));
    sensor_model sensor (.clk(CLK), .rst_n(RST_N), .pri_level(pri_level),
        .aux_level(aux_level), .bo_src(BURNOUT_SRC_EN), .bo_sink(BURNOUT_SINK_EN),
        .pri_raw(PRI_RAW), .aux_raw(AUX_RAW));

    // ==========================================
    // Clock and watchdog
    initial
    begin
        CLK = 1'b0;
        forever #2.5 CLK = ~CLK;
    end
    initial
    begin
        #200_000;
        bad_count++;
        close_out();
    end

    // ==========================================
    // Bus cycles and comparisons
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        HSEL <= 1'b1;
        HTRANS <= 2'b10;
        HADDR <= 32'(a);
        HWRITE <= wr;
        @(posedge CLK);
        while (HREADYOUT !== 1'b1) @(posedge CLK);
        HSEL <= 1'b0;
        HTRANS <= 2'b00;
        HWDATA <= wd;
        @(posedge CLK);
        while (HREADYOUT !== 1'b1) @(posedge CLK);
        rd = HRDATA;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
            bad_count++;
        end
    endtask
    task automatic wbus(input logic [7:0] a, input logic [31:0] wd);
        bus(1'b1, a, wd);
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0000_0000);
        chk(rd, exp);
        chk(32'(HRESP), 32'h0000_0000);
    endtask
    task automatic wait_pri(output int cnt);
        cnt = 0;
        @(posedge CLK);
        while (PRI_DONE !== 1'b1 && cnt < 4000)
        begin
            @(posedge CLK);
            cnt++;
        end
        if (cnt >= 4000)
            bad_count++;
    endtask
    task automatic close_out();
        if (bad_count == 0 && checks_done > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // ==========================================
    // Main sequence
    initial
    begin
        RST_N = 1'b0;
        HSEL = 1'b0;
        HTRANS = 2'b00;
        HADDR = 32'h0000_0000;
        HWRITE = 1'b0;
        HSIZE = 3'h2;
        HWDATA = 32'h0000_0000;
        pri_level = 24'h00_0000;
        aux_level = 16'h0000;
        repeat (4) @(posedge CLK);
        RST_N <= 1'b1;
        wbus(conv_pkg::OFS_DEC_WORD, 32'h0000_0001);
        // Settings rows: pins, burnout routing and read-back with reserved bits zero
        foreach (rows[i])
        begin
            wbus(conv_pkg::OFS_PRI_CFG, 32'(rows[i].pri));
            wbus(conv_pkg::OFS_AUX_CFG, 32'(rows[i].aux));
            wbus(conv_pkg::OFS_CUR_CTL, 32'(rows[i].cur));
            repeat (2) wait_pri(n);
            chk(32'({PRI_POS_PIN, PRI_NEG_PIN, PRI_GAIN, AUX_SRC, AUX_TEMP_SEL,
                EXC_A_PIN1, EXC_A_PIN2, EXC_B_PIN1, EXC_B_PIN2, BURNOUT_SRC_EN}),
                32'(rows[i].outs));
            chk(32'({BURNOUT_SINK_EN, BURNOUT_POS_PIN, BURNOUT_NEG_PIN}),
                32'({rows[i].outs[0], rows[i].outs[16:11]}));
            rchk(conv_pkg::OFS_PRI_CFG, 32'(rows[i].pri & 8'h3F));
            rchk(conv_pkg::OFS_AUX_CFG, 32'(rows[i].aux & 8'h23));
            rchk(conv_pkg::OFS_CUR_CTL, 32'(rows[i].cur & 8'h4F));
        end
        // Result coding on both converters, pins unchanged by the polarity bit
        foreach (codes[i])
        begin
            pri_level <= codes[i].raw;
            aux_level <= codes[i].raw[23:8];
            wbus(conv_pkg::OFS_PRI_CFG, 32'({codes[i].uni, 5'h13}));
            wbus(conv_pkg::OFS_AUX_CFG, 32'({codes[i].uni, 5'h03}));
            repeat (3) wait_pri(n);
            rchk(conv_pkg::OFS_PRI_DATA, 32'(codes[i].code));
            rchk(conv_pkg::OFS_AUX_DATA, 32'(codes[i].code[23:8]));
            chk(32'({PRI_POS_PIN, PRI_NEG_PIN, PRI_GAIN}), 32'({3'h2, 3'h2, 3'h4}));
        end
        // Update period follows the decimation word, zero acting as one
        foreach (decs[i])
        begin
            wbus(conv_pkg::OFS_DEC_WORD, 32'(decs[i]));
            rchk(conv_pkg::OFS_DEC_WORD, 32'(decs[i]));
            repeat (3) wait_pri(n);
            chk(32'(n + 1), 32'(1 + (decs[i] == 8'h00 ? 1 : decs[i]) * UNIT));
        end
        // Channel switch mid-conversion: old result completes, one result dropped
        wbus(conv_pkg::OFS_DEC_WORD, 32'h0000_0045);
        repeat (2) wait_pri(n);
        wbus(conv_pkg::OFS_PRI_CFG, 32'h0000_0000);
        wait_pri(n);
        chk(32'(n < P45), 32'h0000_0001);
        chk(32'(AUX_DONE), 32'h0000_0001);
        bus(1'b0, conv_pkg::OFS_STATUS, 32'h0000_0000);
        chk(32'(rd[3:0]), 32'h0000_0007);
        wait_pri(n);
        chk(32'(n > P45), 32'h0000_0001);
        // Second reset in mid-run with currents on
        wbus(conv_pkg::OFS_CUR_CTL, 32'h0000_0043);
        wbus(conv_pkg::OFS_DEC_WORD, 32'h0000_0013);
        wbus(conv_pkg::OFS_PRI_CFG, 32'h0000_002D);
        wbus(8'h1C, 32'hFFFF_FFFF);
        @(posedge CLK);
        RST_N <= 1'b0;
        @(posedge CLK);
        chk(32'({PRI_POS_PIN, PRI_NEG_PIN, BURNOUT_SRC_EN, EXC_A_PIN1, EXC_B_PIN2}),
            32'({3'h1, 3'h2, 3'h0}));
        RST_N <= 1'b1;
        rchk(conv_pkg::OFS_DEC_WORD, 32'h0000_0045);
        rchk(conv_pkg::OFS_CUR_CTL, 32'h0000_0000);
        rchk(conv_pkg::OFS_PRI_CFG, 32'h0000_0000);
        rchk(8'h1C, 32'h0000_0000);
        close_out();
    end
endmodule
